//--- spps_debounce.sv
// Attach debouncer: qualifies sink presence and absence over the CC debounce time.
// Assumes synchronised inputs on sys_clk.
module spps_debounce
   import spps_pkg::*;
#(
   parameter int unsigned DEB_CYC = CC_DEBOUNCE_CYC
) (
   input  wire logic sys_clk,   // System clock.
   input  wire logic rst,       // Asynchronous reset, active high.
   input  wire logic present,   // Raw qualified sink condition.
   input  wire logic entryOk,   // VBUS low, needed to begin attach.
   output logic      attached   // Debounced attach state.
);
   typedef struct packed {
      logic             att;
      logic [CNT_W-1:0] cnt;
   } spps_db_t;
   spps_db_t st_r, st_nxt;

   // Count while the input disagrees with the held state; restart on agreement.
   always_comb begin
      logic want;
      want   = 1'b0;
      st_nxt = st_r;
      want   = st_r.att ? present : (present && entryOk);
      if (want == st_r.att) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt >= CNT_W'(DEB_CYC - 1)) begin
         st_nxt.att = want;
         st_nxt.cnt = '0;
      end else begin
         st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign attached = st_r.att;
endmodule : spps_debounce

//--- spps_far_model.sv
// Far-side model: the external switched supply and the VBUS it feeds through the gate.
// Assumes the attach indicator enables the supply and the gate drive feeds VBUS.
module spps_far_model
   import spps_pkg::*;
#(
   parameter int unsigned SUP_DLY = 6, // Supply ramp time after attach, in cycles.
   parameter int unsigned VB_DLY  = 4  // VBUS ramp time after gate on, in cycles.
) (
   input  wire logic sys_clk,         // System clock.
   input  wire logic rst,             // Reset, active high.
   input  wire logic supplyEn,        // Attach indicator pulled low.
   input  wire logic gateOn,          // Gate drive from the supervisor.
   input  wire logic supStuckLo,      // Scenario: supply never leaves undervoltage.
   input  wire logic supStuckMid,     // Scenario: supply parks between thresholds.
   input  wire logic vbStuckLo,       // Scenario: VBUS never rises.
   input  wire logic vbForceHi,       // Scenario: foreign source holds VBUS up.
   output logic      supplyBelowFall, // Supply below falling threshold.
   output logic      supplyAboveRise, // Supply above rising threshold.
   output logic      vbusBelowFall,   // VBUS below falling threshold.
   output logic      vbusAboveRise    // VBUS above rising threshold.
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] SUP_TOP = 8'(SUP_DLY);
   localparam logic [7:0] SUP_MID = 8'(SUP_DLY / 2);
   logic [7:0] supCnt_r;
   logic [7:0] vbCnt_r;
   logic [7:0] supCap;

   ////////////////////////////////////////////////////////////////////////////////
   // The supply only ramps while enabled, so it is low whenever nothing is attached.
   assign supCap = supStuckLo ? 8'h00 : (supStuckMid ? SUP_MID : SUP_TOP);

   // Ramp counters; the supply reaches its rising level well inside its allowed time.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         supCnt_r <= 8'h00;
         vbCnt_r  <= 8'h00;
      end else begin
         supCnt_r <= !supplyEn ? 8'h00 : (supCnt_r < supCap ? supCnt_r + 8'h01 : supCap);
         vbCnt_r  <= (!gateOn || vbStuckLo) ? 8'h00 :
                     (vbCnt_r < 8'(VB_DLY) ? vbCnt_r + 8'h01 : vbCnt_r);
      end
   end

   // Comparator levels as the supervisor sees them.
   assign supplyBelowFall = (supCnt_r < SUP_MID) || (supCnt_r == 8'h00);
   assign supplyAboveRise = (supCnt_r == SUP_TOP);
   assign vbusAboveRise   = vbForceHi || (vbCnt_r == 8'(VB_DLY));
   assign vbusBelowFall   = !vbusAboveRise;
endmodule // spps_far_model

//--- spps_pkg.sv
// Constants and types shared by the source port power supervisor.
// Assumes a single 200 MHz system clock and comparator outputs from analog.
// How it works
// - Gate-disable falling edge turns gate off immediately.
// - Gate-disable low 600 ms after attach: hard reset.
// - Supply undervoltage over 600 ms: fault, gate off.
// - Supply between thresholds still permits gate drive.
// - VBUS not up 190 ms after gate: fault.
// - Select outputs encode requested voltage level.
// - Attach indicator floats unattached, low when attached.
// - Attach needs exactly one CC, debounce, VBUS low.
// - Indicator stays low until absence debounced.
// - Digital supply driven high on any valid attach.
// - Aux regulator uses low supply after contract, when it is available.
// - Digital load from high supply unless contract/undervoltage.
// - Thermal shutdown resets the whole device.
// - Sleep when no valid termination attached.
// - Sleep also with dangling active cable.
// - Wake on any plug status change.
// - At power-up refuse gate while VBUS high.
package spps_pkg;
   localparam int unsigned CLK_HZ           = 200_000_000;
   localparam int unsigned FAULT_WAIT_MS    = 600;
   localparam int unsigned VBUS_RISE_MS     = 190;
   localparam int unsigned SUPPLY_RISE_MS   = 275;
   localparam int unsigned CC_DEBOUNCE_US   = 150;
   localparam int unsigned FAULT_WAIT_CYC   = FAULT_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned VBUS_RISE_CYC    = VBUS_RISE_MS * (CLK_HZ / 1000);
   localparam int unsigned CC_DEBOUNCE_CYC  = CC_DEBOUNCE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W            = 32;

   // Requested contract voltage levels.
   typedef enum logic [1:0] {
      VREQ_DEFAULT = 2'h0,
      VREQ_MIDDLE  = 2'h1,
      VREQ_HIGH    = 2'h2
   } spps_vreq_t;

   // Supervisor states.
   typedef enum logic [2:0] {
      ST_CHECK,
      ST_IDLE,
      ST_WAITSUP,
      ST_GATEON,
      ST_RUN,
      ST_FAULT
   } spps_state_t;
endpackage : spps_pkg

//--- spps_supervisor.sv
// Top of the source port power supervisor: attach, gate control, select outputs.
// Assumes analog comparators, a separate message engine for contract and hard reset.
module spps_supervisor
   import spps_pkg::*;
#(
   parameter int unsigned FAULT_CYC = FAULT_WAIT_CYC,  // Undervoltage/disable wait.
   parameter int unsigned VBUS_CYC  = VBUS_RISE_CYC,   // VBUS rise wait.
   parameter int unsigned DEB_CYC   = CC_DEBOUNCE_CYC  // CC debounce.
) (
   input  wire logic       sys_clk,           // 200 MHz clock.
   input  wire logic       rst,               // Asynchronous reset, active high.
   input  wire logic       gate_disable_n,    // Gate-disable pin, async.
   input  wire logic       supplyBelowFall,   // High supply below falling threshold.
   input  wire logic       supplyAboveRise,   // High supply above rising threshold.
   input  wire logic       vbusBelowFall,     // VBUS below falling threshold.
   input  wire logic       vbusAboveRise,     // VBUS above rising threshold.
   input  wire logic [1:0] ccSinkWin,         // Each CC line in the sink window.
   input  wire logic       accessoryAtt,      // Audio or debug accessory detected.
   input  wire logic       danglingCable,     // Active cable with open far end.
   input  wire logic       lowSupplyOk,       // Low-voltage supply available.
   input  wire logic       contractUp,        // Power contract established.
   input  wire logic [1:0] voltReq,           // Requested level, see spps_vreq_t.
   input  wire logic       thermal_shutdown,  // Thermal trip, async.
   output logic            gate_drive_out,    // External gate drive enable.
   output logic            sink_attached_n_oe,// Attach indicator pull-low enable.
   output logic            sink_attached_n_o, // Attach indicator output level.
   output logic            supply_select_lo_oe, // Low select pull-low enable.
   output logic            supply_select_lo_o,  // Low select output level.
   output logic            supply_select_hi_oe, // High select pull-low enable.
   output logic            supply_select_hi_o,  // High select output level.
   output logic            switched_digital_supply_oe, // Digital supply drive enable.
   output logic            switched_digital_supply_o,  // Digital supply level.
   output logic            auxFromLowSupply,  // Aux regulator fed from low supply.
   output logic            digLoadFromHigh,   // Digital load fed from high supply.
   output logic            hardResetReq,      // One-cycle hard reset request.
   output logic            supplyFault,       // Sticky supply fault flag.
   output logic            vbusFault,         // Sticky VBUS rise fault flag.
   output logic            sleepMode          // Sleep mode active.
);
   ////////////////////////////////////////////////////////////////////////////
   // Reset, synchronisation and debounce.

   logic thermSync1_r, thermSync2_r, devRst;

   // A thermal trip resets everything; synchronised so release is clean.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         thermSync1_r <= 1'b0;
         thermSync2_r <= 1'b0;
      end else begin
         thermSync1_r <= thermal_shutdown;
         thermSync2_r <= thermSync1_r;
      end
   end
   assign devRst = rst | thermSync2_r;

   spps_sync_if sif ();

   spps_sync #(.N(7)) u_sync (
      .sys_clk (sys_clk),
      .rst     (devRst),
      .raw     ({ccSinkWin, vbusAboveRise, vbusBelowFall, supplyAboveRise,
                 supplyBelowFall, gate_disable_n}),
      .so      (sif.src)
   );

   logic oneCc, sinkAtt;
   assign oneCc = sif.ccIn[0] ^ sif.ccIn[1];

   spps_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
      .sys_clk  (sys_clk),
      .rst      (devRst),
      .present  (oneCc),
      .entryOk  (sif.vbusLow),
      .attached (sinkAtt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Supervisor state.

   typedef struct packed {
      spps_state_t      state;
      logic             gdPrev;
      logic             gate;
      logic             hrst;
      logic             supFlt;
      logic             vbFlt;
      logic             started;
      logic             vbusBlock;
      logic             sleep;
      logic [1:0]       plugPrev;
      logic [CNT_W-1:0] gdCnt;
      logic [CNT_W-1:0] uvCnt;
      logic [CNT_W-1:0] vbCnt;
   } spps_st_t;
   spps_st_t st_r, st_nxt;

   logic gdFall, validTerm;
   assign gdFall    = st_r.gdPrev & ~sif.gateDisN;
   assign validTerm = sinkAtt | accessoryAtt;

   // Next-state logic; a falling gate-disable edge forces the gate low at once.
   always_comb begin
      logic [1:0] plugNow;
      plugNow          = {danglingCable, validTerm};
      st_nxt           = st_r;
      st_nxt.gdPrev    = sif.gateDisN;
      st_nxt.hrst      = 1'b0;
      st_nxt.plugPrev  = plugNow;
      // First sample after power-up sees the synchroniser reset level, so VBUS is taken as live until seen low.
      if (!st_r.started) begin
         st_nxt.started   = 1'b1;
         st_nxt.vbusBlock = ~sif.vbusLow;
      end else if (st_r.vbusBlock && sif.vbusLow) begin
         st_nxt.vbusBlock = 1'b0;
      end
      // Sleep with no valid termination or a dangling cable; wake on change.
      if (plugNow != st_r.plugPrev) begin
         st_nxt.sleep = 1'b0;
      end else begin
         st_nxt.sleep = ~validTerm | danglingCable;
      end
      // Gate-disable low timer runs only while attached; restarts on release.
      if (sinkAtt && !sif.gateDisN) begin
         st_nxt.gdCnt = st_r.gdCnt + CNT_W'(1);
      end else begin
         st_nxt.gdCnt = '0;
      end
      // Supply undervoltage timer, also restarted on recovery.
      if (sinkAtt && sif.supplyUv) begin
         st_nxt.uvCnt = st_r.uvCnt + CNT_W'(1);
      end else begin
         st_nxt.uvCnt = '0;
      end
      case (st_r.state)
         ST_CHECK: begin
            st_nxt.state = ST_IDLE;
         end
         ST_IDLE: begin
            st_nxt.gate  = 1'b0;
            st_nxt.vbCnt = '0;
            if (sinkAtt) begin
               st_nxt.state = ST_WAITSUP;
            end
         end
         ST_WAITSUP: begin
            // Between thresholds is acceptable; only below falling blocks.
            // A supply fault that outlives a restart still keeps the gate off.
            if (!sif.supplyUv && sif.gateDisN && !st_r.vbusBlock && !st_r.supFlt) begin
               st_nxt.gate  = 1'b1;
               st_nxt.vbCnt = '0;
               st_nxt.state = ST_GATEON;
            end
         end
         ST_GATEON: begin
            st_nxt.vbCnt = st_r.vbCnt + CNT_W'(1);
            if (sif.vbusHigh) begin
               st_nxt.state = ST_RUN;
            end else if (st_r.vbCnt >= CNT_W'(VBUS_CYC - 1)) begin
               st_nxt.gate  = 1'b0;
               st_nxt.vbFlt = 1'b1;
               st_nxt.state = ST_FAULT;
            end
         end
         ST_RUN: begin
            st_nxt.gate = 1'b1;
         end
         ST_FAULT: begin
            st_nxt.gate = 1'b0;
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase
      // Undervoltage fault is terminal until detach.
      if (st_r.uvCnt >= CNT_W'(FAULT_CYC)) begin
         st_nxt.supFlt = 1'b1;
         st_nxt.gate   = 1'b0;
         st_nxt.state  = ST_FAULT;
      end
      // Held gate-disable: hard reset and restart from the top.
      if (sinkAtt && st_r.gdCnt >= CNT_W'(FAULT_CYC - 1)) begin
         st_nxt.hrst  = 1'b1;
         st_nxt.gate  = 1'b0;
         st_nxt.gdCnt = '0;
         st_nxt.state = ST_CHECK;
      end
      // Detach ends any session and clears its fault flags.
      if (!sinkAtt && st_r.state != ST_CHECK) begin
         st_nxt.state  = ST_IDLE;
         st_nxt.gate   = 1'b0;
         st_nxt.supFlt = 1'b0;
         st_nxt.vbFlt  = 1'b0;
      end
      if (gdFall || !sif.gateDisN) begin
         st_nxt.gate = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge devRst) begin
      if (devRst) begin
         st_r <= '{state: ST_CHECK, gdPrev: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Gate is also cut combinationally so a disable edge acts within a cycle.
   assign gate_drive_out = st_r.gate & sif.gateDisN;
   assign hardResetReq   = st_r.hrst;
   assign supplyFault    = st_r.supFlt;
   assign vbusFault      = st_r.vbFlt;
   assign sleepMode      = st_r.sleep;

   // Open-drain pins only ever pull low with their level output at zero; the digital supply is driven high on valid termination.
   assign sink_attached_n_oe  = sinkAtt;
   assign sink_attached_n_o   = 1'b0;
   assign supply_select_lo_oe = sinkAtt && (voltReq == VREQ_MIDDLE || voltReq == VREQ_HIGH);
   assign supply_select_lo_o  = 1'b0;
   assign supply_select_hi_oe = sinkAtt && (voltReq == VREQ_HIGH);
   assign supply_select_hi_o  = 1'b0;
   assign switched_digital_supply_oe = validTerm;
   assign switched_digital_supply_o  = validTerm;
   assign auxFromLowSupply = contractUp & lowSupplyOk;
   assign digLoadFromHigh  = ~contractUp & ~sif.supplyUv;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_GATE_DIS: assert property (@(posedge sys_clk) disable iff (devRst)
      !sif.gateDisN |-> !gate_drive_out) else $error("gate on while disabled");
   AST_GATE_REG: assert property (@(posedge sys_clk) disable iff (devRst)
      !sif.gateDisN |=> !st_r.gate) else $error("gate register set while disabled");
   AST_HRST: assert property (@(posedge sys_clk) disable iff (devRst)
      st_r.hrst |-> st_r.state == ST_CHECK) else $error("hard reset without restart");
   AST_UVF: assert property (@(posedge sys_clk) disable iff (devRst)
      st_r.supFlt |-> !gate_drive_out) else $error("gate on under supply fault");
   AST_VBF: assert property (@(posedge sys_clk) disable iff (devRst)
      $rose(st_r.vbFlt) |-> $past(st_r.state) == ST_GATEON) else $error("vbus fault source");
   AST_SEL: assert property (@(posedge sys_clk) disable iff (devRst)
      supply_select_hi_oe |-> supply_select_lo_oe) else $error("select order");
   AST_ATT: assert property (@(posedge sys_clk) disable iff (devRst)
      sink_attached_n_oe == sinkAtt) else $error("attach pin");
   AST_DETACH: assert property (@(posedge sys_clk) disable iff (devRst)
      $fell(sinkAtt) |-> !$past(oneCc)) else $error("attach dropped while sink present");
   AST_SWITCHED_DIGITAL_SUPPLY: assert property (@(posedge sys_clk) disable iff (devRst)
      sinkAtt |-> switched_digital_supply_oe) else $error("digital supply");
   AST_BLOCK: assert property (@(posedge sys_clk) disable iff (devRst)
      st_r.vbusBlock |-> !st_r.gate) else $error("gate on with live vbus");
   COV_RUN: cover property (@(posedge sys_clk) st_r.state == ST_RUN);
   COV_HRST: cover property (@(posedge sys_clk) st_r.hrst);
   COV_VBF: cover property (@(posedge sys_clk) st_r.vbFlt);
   COV_MIDSUP: cover property (@(posedge sys_clk) st_r.gate && !sif.supplyOk);
endmodule : spps_supervisor

//--- spps_sync.sv
// Two-flop synchronisers for the gate-disable pin and every comparator input.
// Assumes inputs come from analog comparators with no timing relation to sys_clk.
module spps_sync
   import spps_pkg::*;
#(
   parameter int unsigned N = 7
) (
   input  wire logic    sys_clk, // System clock.
   input  wire logic    rst,     // Asynchronous reset, active high.
   input  wire logic [N-1:0] raw, // Raw levels.
   spps_sync_if.src     so       // Synchronised levels.
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
   } spps_sy_t;
   spps_sy_t st_r, st_nxt;

   // First stage feeds only the second stage, to contain metastability.
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = raw;
      st_nxt.s2 = st_r.s1;
   end

   // Reset value of the gate-disable bit is high so no false edge appears.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= '{s1: {{(N-1){1'b0}}, 1'b1}, s2: {{(N-1){1'b0}}, 1'b1}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign so.gateDisN = st_r.s2[0];
   assign so.supplyUv = st_r.s2[1];
   assign so.supplyOk = st_r.s2[2];
   assign so.vbusLow  = st_r.s2[3];
   assign so.vbusHigh = st_r.s2[4];
   assign so.ccIn     = st_r.s2[6:5];
endmodule : spps_sync

//--- spps_sync_if.sv
// Carrier for synchronised comparator and pin levels inside the supervisor.
// Assumes the producer and consumer share sys_clk.
interface spps_sync_if;
   logic gateDisN;   // Gate-disable pin level, synchronised.
   logic supplyUv;   // High supply below falling threshold.
   logic supplyOk;   // High supply above rising threshold.
   logic vbusLow;    // VBUS below falling threshold.
   logic vbusHigh;   // VBUS above rising threshold.
   logic [1:0] ccIn; // CC lines within the sink window.
   modport src (output gateDisN, supplyUv, supplyOk, vbusLow, vbusHigh, ccIn);
   modport dst (input gateDisN, supplyUv, supplyOk, vbusLow, vbusHigh, ccIn);
endinterface : spps_sync_if

//--- tb_top.sv
// Self-checking bench for the source port power supervisor and its far side.
// Assumes shortened interval parameters so every wait is a few dozen cycles.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import spps_pkg::*;
   localparam int unsigned FC = 50; // Shortened fault interval.
   localparam int unsigned VC = 30; // Shortened VBUS rise interval.
   localparam int unsigned DC = 8;  // Shortened CC debounce.
   logic sys_clk = 1'b0, rst = 1'b1, gateDisN = 1'b1, accAtt = 1'b0, dangle = 1'b0;
   logic lowOk = 1'b0, contract = 1'b0, thermal = 1'b0, supLo = 1'b0, supMid = 1'b0;
   logic vbStuck = 1'b0, vbForce = 1'b0;
   logic [1:0] cc = 2'b00, vreq = 2'h0;
   logic gate, attOe, attO, loOe, loO, hiOe, hiO, digOe, digO, auxLow, digHigh;
   logic hrr, supF, vbF, slp, sBF, sAR, vBF, vAR;
   int   n_tests = 0, fail_count = 0;

   always #2.5 sys_clk = ~sys_clk;

   spps_supervisor #(.FAULT_CYC(FC), .VBUS_CYC(VC), .DEB_CYC(DC)) i_spps_supervisor (
      .sys_clk(sys_clk), .rst(rst), .gate_disable_n(gateDisN), .supplyBelowFall(sBF),
      .supplyAboveRise(sAR), .vbusBelowFall(vBF), .vbusAboveRise(vAR), .ccSinkWin(cc),
      .accessoryAtt(accAtt), .danglingCable(dangle), .lowSupplyOk(lowOk),
      .contractUp(contract), .voltReq(vreq), .thermal_shutdown(thermal),
      .gate_drive_out(gate), .sink_attached_n_oe(attOe), .sink_attached_n_o(attO),
      .supply_select_lo_oe(loOe), .supply_select_lo_o(loO), .supply_select_hi_oe(hiOe),
      .supply_select_hi_o(hiO), .switched_digital_supply_oe(digOe),
      .switched_digital_supply_o(digO), .auxFromLowSupply(auxLow),
      .digLoadFromHigh(digHigh), .hardResetReq(hrr), .supplyFault(supF),
      .vbusFault(vbF), .sleepMode(slp));

   spps_far_model i_spps_far_model (
      .sys_clk(sys_clk), .rst(rst), .supplyEn(attOe), .gateOn(gate), .supStuckLo(supLo),
      .supStuckMid(supMid), .vbStuckLo(vbStuck), .vbForceHi(vbForce),
      .supplyBelowFall(sBF), .supplyAboveRise(sAR), .vbusBelowFall(vBF),
      .vbusAboveRise(vAR));

   ////////////////////////////////////////////////////////////////////////////////
   // Output selector so one bounded wait serves every watched flag.
   function automatic logic pick(input int s);
      case (s)
         0: return gate;
         1: return attOe;
         2: return digOe;
         3: return vbF;
         4: return supF;
         5: return slp;
         default: return hrr;
      endcase
   endfunction

   task automatic results();
      $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Bounded wait; running out of cycles is a mismatch and ends the run.
   task automatic waitSig(input int s, input logic v, input int bound, input string nm);
      int k;
      k = 0;
      while (pick(s) !== v && k < bound) begin
         @(negedge sys_clk);
         k++;
      end
      chk(nm, v, pick(s));
      if (pick(s) !== v) results();
   endtask

   // A flag must keep its level for every sampled cycle of the span.
   task automatic holdSig(input int s, input logic v, input int n, input string nm);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(negedge sys_clk);
         if (pick(s) !== v) ok = 1'b0;
      end
      chk(nm, 1'b1, ok);
   endtask

   task automatic plug(input logic [1:0] line);
      cc = line;
      waitSig(1, 1'b1, DC + 8, "attach");
   endtask

   task automatic unplug();
      cc = 2'b00;
      waitSig(1, 1'b0, DC + 8, "detach");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Power-up with a foreign source on VBUS, then a supply parked between thresholds.
   task automatic scPowerUp();
      vbForce = 1'b1;
      supMid = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      cc = 2'b01;
      holdSig(1, 1'b0, 3 * DC, "attach while VBUS high");
      holdSig(0, 1'b0, 8, "gate while VBUS high at power-up");
      vbForce = 1'b0;
      waitSig(1, 1'b1, 3 * DC, "attach after VBUS drops");
      waitSig(0, 1'b1, 20, "gate with supply between thresholds");
      holdSig(3, 1'b0, VC + 5, "no fault when VBUS rises");
      supMid = 1'b0;
   endtask

   task automatic scOutputs();
      chk("attach level", 1'b0, attO);
      chk("digital supply level", 1'b1, digO);
      chk("sleep while attached", 1'b0, slp);
      for (int v = 0; v < 3; v++) begin
         vreq = 2'(v);
         @(negedge sys_clk);
         chk("low select", v != 0, loOe);
         chk("high select", v == 2, hiOe);
      end
      chk("select levels", 1'b0, loO | hiO);
      for (int c = 0; c < 4; c++) begin
         {contract, lowOk} = 2'(c);
         @(negedge sys_clk);
         chk("aux source", c == 3, auxLow);
         chk("digital load source", !(contract || sBF), digHigh);
      end
      {contract, lowOk} = 2'b00;
   endtask

   // Interrupted disable restarts its count; a full one asks for a hard reset.
   task automatic scDisable();
      gateDisN = 1'b0;
      waitSig(0, 1'b0, 3, "gate off after disable edge");
      holdSig(6, 1'b0, FC - 10, "no hard reset early");
      gateDisN = 1'b1;
      repeat (5) @(negedge sys_clk);
      gateDisN = 1'b0;
      holdSig(6, 1'b0, FC - 10, "count restarts after release");
      waitSig(6, 1'b1, 25, "hard reset after long disable");
      @(negedge sys_clk);
      chk("hard reset single pulse", 1'b0, hrr);
      gateDisN = 1'b1;
      waitSig(0, 1'b1, 60, "gate back after restart");
   endtask

   task automatic scDetach();
      cc = 2'b00;
      holdSig(1, 1'b1, DC - 3, "attach held in short absence");
      cc = 2'b01;
      holdSig(1, 1'b1, 2 * DC, "attach held after glitch");
      unplug();
      waitSig(5, 1'b1, 6, "sleep when unattached");
      cc = 2'b11;
      holdSig(1, 1'b0, 3 * DC, "no attach on both lines");
      cc = 2'b00;
   endtask

   task automatic scSleep();
      dangle = 1'b1;
      waitSig(5, 1'b0, 5, "wake on cable plug");
      waitSig(5, 1'b1, 5, "sleep with dangling cable");
      dangle = 1'b0;
      waitSig(5, 1'b0, 5, "wake on cable removal");
      accAtt = 1'b1;
      waitSig(2, 1'b1, 6, "digital supply for accessory");
      holdSig(5, 1'b0, 5, "awake with accessory");
      accAtt = 1'b0;
      waitSig(2, 1'b0, 6, "digital supply floats again");
   endtask

   task automatic scVbusDead();
      vbStuck = 1'b1;
      plug(2'b10);
      waitSig(0, 1'b1, 20, "gate on");
      holdSig(3, 1'b0, VC - 4, "no early VBUS fault");
      waitSig(3, 1'b1, 10, "VBUS fault");
      chk("gate off on VBUS fault", 1'b0, gate);
      unplug();
      vbStuck = 1'b0;
   endtask

   task automatic scSupplyLow();
      supLo = 1'b1;
      plug(2'b01);
      chk("digital load off low supply", 1'b0, digHigh);
      holdSig(4, 1'b0, FC - 8, "no early supply fault");
      waitSig(4, 1'b1, 16, "supply fault");
      supLo = 1'b0;
      holdSig(0, 1'b0, 12, "gate stays off after fault");
      unplug();
   endtask

   task automatic scThermal();
      plug(2'b01);
      waitSig(0, 1'b1, 20, "gate on");
      thermal = 1'b1;
      waitSig(1, 1'b0, 5, "attach cleared by thermal trip");
      chk("gate off on thermal trip", 1'b0, gate);
      thermal = 1'b0;
      unplug();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence; inputs change on falling edges only.
   initial begin
      @(negedge sys_clk);
      scPowerUp();
      scOutputs();
      scDisable();
      scDetach();
      scSleep();
      scVbusDead();
      scSupplyLow();
      scThermal();
      results();
   end
endmodule // tb_top
